// File: core/pll_clock_generator_pkg.sv
// constants for the clock generator register block
// assumes a 32-bit bus with one register per aligned word
package pll_clock_generator_pkg;

  // byte offsets of the registers
  localparam logic [7:0] OFF_LOOP_CONTROL = 8'h00;
  localparam logic [7:0] OFF_BANDWIDTH    = 8'h04;
  localparam logic [7:0] OFF_MUL_HIGH     = 8'h08;
  localparam logic [7:0] OFF_MUL_LOW      = 8'h0c;
  localparam logic [7:0] OFF_VCO_RANGE    = 8'h10;
  localparam logic [7:0] OFF_REF_DIVIDER  = 8'h14;

  // loop control field positions
  localparam int BIT_IRQ_ENABLE = 7;
  localparam int BIT_LOCK_FLAG  = 6;
  localparam int BIT_LOOP_EN    = 5;
  localparam int BIT_BASE_SEL   = 4;
  localparam int BIT_PRE_HI     = 3;
  localparam int BIT_PRE_LO     = 2;
  localparam int BIT_VPR_HI     = 1;
  localparam int BIT_VPR_LO     = 0;

  // bandwidth control field positions
  localparam int BIT_AUTO       = 7;
  localparam int BIT_LOCK       = 6;
  localparam int BIT_ACQ        = 5;

  // field widths
  localparam int MUL_WIDTH      = 12;
  localparam int RANGE_WIDTH    = 8;
  localparam int DIV_WIDTH      = 4;

  // reset values
  localparam logic [11:0] RST_MULTIPLIER = 12'h040;
  localparam logic [7:0]  RST_VCO_RANGE  = 8'h40;
  localparam logic [3:0]  RST_REF_DIV    = 4'h1;

  // source edges waited on each side of a switch-over
  localparam int SWITCH_EDGES   = 3;

  // ahb encodings
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
  localparam logic [2:0]  HSIZE_WORD     = 3'b010;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  typedef enum logic [1:0] {SW_RUN, SW_DRAIN_OLD, SW_FILL_NEW} switch_state_t;

endpackage : pll_clock_generator_pkg

// File: core/pll_clock_generator_registers.sv
// control and status registers of the pll clock generator, with the
// glitch-free base clock selector
// assumes an ahb-lite master on clock; lock, acquisition and both source
// clocks arrive asynchronously and are synchronised here
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module pll_clock_generator_registers
  import pll_clock_generator_pkg::*;
#(
  parameter int SWITCH_COUNT = pll_clock_generator_pkg::SWITCH_EDGES
)
(
  input  wire logic                                       clock,
  input  wire logic                                       rst_n,
  input  wire logic                                       hsel,
  input  wire logic [31:0]                                haddr,
  input  wire logic [1:0]                                 htrans,
  input  wire logic                                       hwrite,
  input  wire logic [2:0]                                 hsize,
  input  wire logic [31:0]                                hwdata,
  input  wire logic                                       hready,
  output logic                                            hreadyout,
  output logic                                            hresp,
  output logic [31:0]                                     hrdata,
  input  wire logic                                       lock_detect,
  input  wire logic                                       track_detect,
  input  wire logic                                       oscillator_clock,
  input  wire logic                                       divided_vco_clock,
  output logic                                            base_clock_out,
  output logic                                            lock_irq,
  output logic                                            loop_enable,
  output logic                                            auto_bandwidth,
  output logic                                            acquire_track_select,
  output logic [1:0]                                      prescaler,
  output logic [1:0]                                      range_exponent,
  output logic [pll_clock_generator_pkg::MUL_WIDTH-1:0]   feedback_multiplier,
  output logic [pll_clock_generator_pkg::RANGE_WIDTH-1:0] vco_linear_range,
  output logic [pll_clock_generator_pkg::DIV_WIDTH-1:0]   reference_divide_value
);
  import pll_clock_generator_pkg::*;

  // the edge counter is four bits wide
  if (SWITCH_COUNT < 1 || SWITCH_COUNT > 15)
  begin : g_bad_switch_count
    $error("SWITCH_COUNT must lie in 1..15");
  end

  // a programmed zero means one for the dividers
  function automatic logic [MUL_WIDTH-1:0] zero_as_one(input logic [MUL_WIDTH-1:0] v);
    zero_as_one = (v == '0) ? MUL_WIDTH'(1) : v;
  endfunction : zero_as_one

  ////////////////////////////////////////////////////////////////////////
  // state

  logic                   irq_enable;
  logic                   lock_flag;
  logic                   base_clock_select;
  logic                   acq_manual;
  logic [MUL_WIDTH-1:0]   multiplier;
  logic [DIV_WIDTH-1:0]   ref_divider;
  logic                   lock_state;
  logic [1:0]             lock_sync;
  logic [1:0]             track_sync;
  logic [2:0]             osc_sync;
  logic [2:0]             vco_sync;
  logic                   dp_write;
  logic [7:0]             dp_addr;
  logic                   active_sel;
  logic [3:0]             edge_count;
  switch_state_t          sw_state;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire       addr_phase  = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire       rd_accept   = addr_phase & ~hwrite;
  wire [7:0] rd_addr     = haddr[7:0];
  wire       wr_word     = dp_write;
  wire [7:0] wdat        = hwdata[7:0];
  wire       mapped_hi   = (haddr[31:8] == 24'h00_0000);

  // register writes land at the end of the data phase
  wire wr_ctrl   = wr_word & (dp_addr == OFF_LOOP_CONTROL);
  wire wr_bw     = wr_word & (dp_addr == OFF_BANDWIDTH);
  wire wr_mul_hi = wr_word & (dp_addr == OFF_MUL_HIGH);
  wire wr_mul_lo = wr_word & (dp_addr == OFF_MUL_LOW);
  wire wr_range  = wr_word & (dp_addr == OFF_VCO_RANGE);
  wire wr_div    = wr_word & (dp_addr == OFF_REF_DIVIDER);

  // the loop-on interlock covers every programming field
  wire programmable = ~loop_enable;
  wire range_zero   = (vco_linear_range == '0);

  ////////////////////////////////////////////////////////////////////////
  // next values of the loop control fields

  wire next_loop_en_wr  = wdat[BIT_LOOP_EN] | base_clock_select;
  wire next_loop_enable = range_zero ? 1'b0
                        : (wr_ctrl ? next_loop_en_wr : loop_enable);
  wire sel_allowed      = loop_enable & ~range_zero;
  wire next_base_sel_wr = wdat[BIT_BASE_SEL] & sel_allowed;
  wire next_base_select = range_zero ? 1'b0
                        : (wr_ctrl ? next_base_sel_wr : base_clock_select);
  wire next_irq_enable  = (wr_ctrl & auto_bandwidth) ? wdat[BIT_IRQ_ENABLE]
                        : irq_enable;

  // lock indicator only means something in automatic mode
  wire next_lock_state  = auto_bandwidth & lock_sync[1];
  wire lock_toggle      = auto_bandwidth & (next_lock_state != lock_state);
  wire ctrl_read        = rd_accept & mapped_hi & (rd_addr == OFF_LOOP_CONTROL);
  // a new toggle beats the read-clear in the same cycle
  wire next_lock_flag   = lock_toggle | (lock_flag & ~ctrl_read);

  wire next_acq_manual  = (wr_bw & ~auto_bandwidth) ? wdat[BIT_ACQ]
                        : acq_manual;

  ////////////////////////////////////////////////////////////////////////
  // read mux

  wire       flag_view  = lock_flag & auto_bandwidth;
  wire       ien_view   = irq_enable & auto_bandwidth;
  wire       acq_view   = auto_bandwidth ? track_sync[1] : acq_manual;
  wire [7:0] ctrl_view  = {ien_view, flag_view, loop_enable, base_clock_select,
                           prescaler, range_exponent};
  wire [7:0] bw_view    = {auto_bandwidth, lock_state, acq_view, 5'b0_0000};
  wire [7:0] mulh_view  = {4'h0, multiplier[MUL_WIDTH-1:8]};
  wire [7:0] mull_view  = multiplier[7:0];
  wire [7:0] div_view   = {4'h0, ref_divider};

  wire [7:0] rd_byte =
      !mapped_hi                    ? 8'h00 :
      (rd_addr == OFF_LOOP_CONTROL) ? ctrl_view :
      (rd_addr == OFF_BANDWIDTH)    ? bw_view :
      (rd_addr == OFF_MUL_HIGH)     ? mulh_view :
      (rd_addr == OFF_MUL_LOW)      ? mull_view :
      (rd_addr == OFF_VCO_RANGE)    ? vco_linear_range :
      (rd_addr == OFF_REF_DIVIDER)  ? div_view : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always okay

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // capture the address phase; read data is ready for the data phase
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      hrdata   <= ZERO_WORD;
    end
    else
    begin
      dp_write <= addr_phase & hwrite & mapped_hi & (hsize == HSIZE_WORD);
      dp_addr  <= rd_addr;
      if (rd_accept)
        hrdata <= {24'h00_0000, rd_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and status registers

  // loop control register and its interlocks
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      irq_enable        <= 1'b0;
      lock_flag         <= 1'b0;
      loop_enable       <= 1'b1;
      base_clock_select <= 1'b0;
      prescaler         <= 2'b00;
      range_exponent    <= 2'b00;
    end
    else
    begin
      irq_enable        <= next_irq_enable;
      lock_flag         <= next_lock_flag;
      loop_enable       <= next_loop_enable;
      base_clock_select <= next_base_select;
      if (wr_ctrl && programmable)
      begin
        prescaler      <= wdat[BIT_PRE_HI:BIT_PRE_LO];
        range_exponent <= wdat[BIT_VPR_HI:BIT_VPR_LO];
      end
    end
  end

  // bandwidth control; lock position writes are dropped
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      auto_bandwidth <= 1'b0;
      lock_state     <= 1'b0;
      acq_manual     <= 1'b0;
    end
    else
    begin
      if (wr_bw)
        auto_bandwidth <= wdat[BIT_AUTO];
      lock_state <= next_lock_state;
      acq_manual <= next_acq_manual;
    end
  end

  // programming registers, frozen while the loop runs
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      multiplier       <= RST_MULTIPLIER;
      vco_linear_range <= RST_VCO_RANGE;
      ref_divider      <= RST_REF_DIV;
    end
    else if (programmable)
    begin
      if (wr_mul_hi)
        multiplier[MUL_WIDTH-1:8] <= wdat[MUL_WIDTH-9:0];
      if (wr_mul_lo)
        multiplier[7:0] <= wdat;
      if (wr_range)
        vco_linear_range <= wdat;
      if (wr_div)
        ref_divider <= wdat[DIV_WIDTH-1:0];
    end
  end

  // effective values handed to the loop
  assign feedback_multiplier    = zero_as_one(multiplier);
  assign reference_divide_value = (ref_divider == '0) ? DIV_WIDTH'(1)
                                                      : ref_divider;
  assign acquire_track_select   = acq_manual;
  assign lock_irq               = flag_view & ien_view;

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for asynchronous inputs

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      lock_sync  <= 2'b00;
      track_sync <= 2'b00;
      osc_sync   <= 3'b000;
      vco_sync   <= 3'b000;
    end
    else
    begin
      lock_sync  <= {lock_sync[0], lock_detect};
      track_sync <= {track_sync[0], track_detect};
      osc_sync   <= {osc_sync[1:0], oscillator_clock};
      vco_sync   <= {vco_sync[1:0], divided_vco_clock};
    end
  end

  // edge detectors look only past the first stage
  wire osc_rise = osc_sync[1] & ~osc_sync[2];
  wire vco_rise = vco_sync[1] & ~vco_sync[2];

  ////////////////////////////////////////////////////////////////////////
  // base clock selector: drain old source, fill new, then toggle on

  wire old_rise  = active_sel ? vco_rise : osc_rise;
  wire new_rise  = active_sel ? osc_rise : vco_rise;
  wire last_edge = (edge_count == 4'(SWITCH_COUNT - 1));

  // output is held in stasis outside sw_run; a stopped source stalls
  // the switch, which the loop-on interlock keeps from happening only while base_clock_select is set
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sw_state       <= SW_RUN;
      active_sel     <= 1'b0;
      edge_count     <= 4'h0;
      base_clock_out <= 1'b0;
    end
    else
    begin
      case (sw_state)
        SW_RUN:
        begin
          if (base_clock_select != active_sel)
          begin
            sw_state   <= SW_DRAIN_OLD;
            edge_count <= 4'h0;
          end
          else if (old_rise)
            base_clock_out <= ~base_clock_out;
        end
        SW_DRAIN_OLD:
        begin
          if (old_rise)
          begin
            edge_count <= last_edge ? 4'h0 : edge_count + 4'h1;
            if (last_edge)
              sw_state <= SW_FILL_NEW;
          end
        end
        SW_FILL_NEW:
        begin
          if (new_rise)
          begin
            edge_count <= last_edge ? 4'h0 : edge_count + 4'h1;
            if (last_edge)
            begin
              sw_state   <= SW_RUN;
              active_sel <= ~active_sel;
            end
          end
        end
        default:
          sw_state <= SW_RUN;
      endcase
    end
  end

endmodule : pll_clock_generator_registers

`default_nettype wire

// File: verification/pll_clock_generator_registers_sva.sv
// checker for the clock generator register block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/10ps
`default_nettype none

module pll_clock_generator_registers_sva
  import pll_clock_generator_pkg::*;
#(
  parameter int SWITCH_COUNT = 3
)
(
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic [31:0]            hrdata,
  input wire logic                   lock_detect,
  input wire logic                   track_detect,
  input wire logic                   oscillator_clock,
  input wire logic                   divided_vco_clock,
  input wire logic                   base_clock_out,
  input wire logic                   lock_irq,
  input wire logic                   loop_enable,
  input wire logic                   auto_bandwidth,
  input wire logic                   acquire_track_select,
  input wire logic [1:0]             prescaler,
  input wire logic [1:0]             range_exponent,
  input wire logic [MUL_WIDTH-1:0]   feedback_multiplier,
  input wire logic [RANGE_WIDTH-1:0] vco_linear_range,
  input wire logic [DIV_WIDTH-1:0]   reference_divide_value
);

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // lock input history, newest first; a toggle reaches the flag at edge n only
  // when the input differed between edges n-3 and n-2
  logic [2:0] lock_hist;

  always_ff @(posedge clock)
  begin
    lock_hist <= {lock_hist[1:0], lock_detect};
  end

  // read of loop control taken; lock input quiet so no toggle races the clear
  wire rd_ctl = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr == ZERO_WORD;
  wire quiet  = (lock_hist[1] == lock_hist[2]);

  //////////////////////////////////////////////////////////////////////////////
  chk_bus_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h00_0000)
    else $error("bus answer not zero-wait okay");
  chk_reset_load: assert property (
    disable iff (1'b0) !rst_n |=> loop_enable && !auto_bandwidth && prescaler == 2'b00
      && feedback_multiplier == 12'h040 && vco_linear_range == 8'h40
      && reference_divide_value == 4'h1 && !lock_irq && !acquire_track_select)
    else $error("reset values wrong");
  chk_pre_locked: assert property (
    loop_enable |=> $stable(prescaler) && $stable(range_exponent))
    else $error("prescaler or exponent changed with loop on");
  chk_fields_locked: assert property (
    loop_enable |=> $stable(feedback_multiplier) && $stable(vco_linear_range)
      && $stable(reference_divide_value))
    else $error("divider field changed with loop on");
  chk_zero_as_one: assert property (
    feedback_multiplier != 12'h000 && reference_divide_value != 4'h0)
    else $error("zero divider value reached output");
  chk_range_zero_off: assert property (vco_linear_range == 8'h00 |-> !loop_enable)
    else $error("loop on with zero range");
  chk_irq_needs_auto: assert property (lock_irq |-> auto_bandwidth)
    else $error("interrupt in manual mode");
  chk_read_clears: assert property (rd_ctl && lock_irq && quiet |=> !lock_irq)
    else $error("control read left flag set");
  chk_acq_held: assert property (auto_bandwidth |=> $stable(acquire_track_select))
    else $error("manual acquisition value lost in auto mode");

  // main scenarios reached
  cover property (rd_ctl && lock_irq);
  cover property ($rose(base_clock_out) && loop_enable);
  cover property (vco_linear_range == 8'h00);

endmodule : pll_clock_generator_registers_sva

bind pll_clock_generator_registers pll_clock_generator_registers_sva #(
  .SWITCH_COUNT(SWITCH_COUNT)
) u_sva (
  .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hreadyout, .hresp, .hrdata, .lock_detect, .track_detect, .oscillator_clock,
  .divided_vco_clock, .base_clock_out, .lock_irq, .loop_enable, .auto_bandwidth,
  .acquire_track_select, .prescaler, .range_exponent, .feedback_multiplier,
  .vco_linear_range, .reference_divide_value
);

`default_nettype wire

// File: verification/tb.sv
// testbench for the clock generator register block
// assumes the block is the only ahb-lite slave and makes hready itself
`timescale 1ns/10ps
`default_nettype none

module tb;
  import pll_clock_generator_pkg::*;

  logic                   clock = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   hsel = 1'b1;
  logic [31:0]            haddr = ZERO_WORD;
  logic [1:0]             htrans = 2'b00;
  logic                   hwrite = 1'b0;
  logic [2:0]             hsize = 3'b000;
  logic [31:0]            hwdata = ZERO_WORD;
  logic                   lock_detect = 1'b0;
  logic                   track_detect = 1'b0;
  logic                   oscillator_clock = 1'b0;
  logic                   divided_vco_clock = 1'b0;
  logic                   hreadyout, hresp, base_clock_out, lock_irq;
  logic                   loop_enable, auto_bandwidth, acquire_track_select;
  logic [31:0]            hrdata;
  logic [1:0]             prescaler, range_exponent;
  logic [MUL_WIDTH-1:0]   feedback_multiplier;
  logic [RANGE_WIDTH-1:0] vco_linear_range;
  logic [DIV_WIDTH-1:0]   reference_divide_value;
  int                     n_mismatch = 0;
  int                     tests_run = 0;
  int                     cycles = 0;
  int                     i;
  logic                   b, frozen;
  logic [31:0]            rv [0:6] = '{32'h20, 32'h00, 32'h00, 32'h40, 32'h40, 32'h01, 32'h00};

  // bench clock and two slow source clocks, phases unrelated to it
  always #5 clock = ~clock;
  always #40 oscillator_clock = ~oscillator_clock;
  always #60 divided_vco_clock = ~divided_vco_clock;

  pll_clock_generator_registers u_dut (
    .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .lock_detect, .track_detect, .oscillator_clock,
    .divided_vco_clock, .base_clock_out, .lock_irq, .loop_enable, .auto_bandwidth,
    .acquire_track_select, .prescaler, .range_exponent, .feedback_multiplier,
    .vco_linear_range, .reference_divide_value
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  // one single word transfer; the wait ends only on hready or the timeout
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, ZERO_WORD, q);
    check(q, e);
  endtask : rd

  // base output toggles on each source rise, so its period is two source periods
  task automatic period(input int p);
    time t0;
    @(posedge base_clock_out);
    @(posedge base_clock_out);
    t0 = $time;
    @(posedge base_clock_out);
    check(32'(($time - t0 > 2 * p - 15) && ($time - t0 < 2 * p + 15)), 32'h1);
  endtask : period

  //////////////////////////////////////////////////////////////////////////////
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 7; i++) rd(8'(4 * i), rv[i]);
    // with the loop on every divider field refuses writes
    wr(8'h00, 32'h2f);
    rd(8'h00, 32'h20);
    for (i = 2; i < 6; i++) wr(8'(4 * i), 32'h05);
    for (i = 2; i < 6; i++) rd(8'(4 * i), rv[i]);
    // switch to the loop clock: output frozen, then runs on the new source
    wr(8'h00, 32'h30);
    @(posedge clock);
    b = base_clock_out;
    frozen = 1'b1;
    repeat (28) @(posedge clock) if (base_clock_out !== b) frozen = 1'b0;
    check(32'(frozen), 32'h1);
    period(120);
    rd(8'h00, 32'h30);
    wr(8'h00, 32'h00);
    rd(8'h00, 32'h20);
    period(80);
    wr(8'h00, 32'h00);
    wr(8'h00, 32'h10);
    rd(8'h00, 32'h00);
    // loop off: every prescaler code and every legal exponent code
    for (i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'(4 * i + i % 3));
      @(posedge clock);
      check(32'({prescaler, range_exponent}), 32'(4 * i + i % 3));
    end
    wr(8'h08, 32'h00);
    wr(8'h0c, 32'h00);
    wr(8'h14, 32'h00);
    @(posedge clock);
    check(32'(feedback_multiplier), 32'h1);
    check(32'(reference_divide_value), 32'h1);
    wr(8'h08, 32'h03);
    wr(8'h0c, 32'h84);
    wr(8'h14, 32'h01);
    @(posedge clock);
    check(32'(feedback_multiplier), 32'h384);
    // zero range keeps the loop and the select off
    wr(8'h10, 32'h00);
    wr(8'h00, 32'h2c);
    wr(8'h00, 32'h3c);
    rd(8'h00, 32'h0c);
    wr(8'h10, 32'h40);
    // bandwidth modes, lock flag and interrupt
    wr(8'h00, 32'h80);
    rd(8'h00, 32'h00);
    wr(8'h04, 32'h20);
    rd(8'h04, 32'h20);
    wr(8'h04, 32'ha0);
    rd(8'h04, 32'h80);
    track_detect <= 1'b1;
    wr(8'h00, 32'h80);
    lock_detect <= 1'b1;
    repeat (6) @(posedge clock);
    check(32'(lock_irq), 32'h1);
    rd(8'h04, 32'he0);
    check(32'(acquire_track_select), 32'h1);
    rd(8'h00, 32'hc0);
    rd(8'h00, 32'h80);
    check(32'(lock_irq), 32'h0);
    lock_detect <= 1'b0;
    repeat (6) @(posedge clock);
    wr(8'h00, 32'h80);
    @(posedge clock);
    check(32'(lock_irq), 32'h1);
    wr(8'h04, 32'h00);
    @(posedge clock);
    check(32'(lock_irq), 32'h0);
    rd(8'h00, 32'h00);
    rd(8'h04, 32'h20);
    // manual mode bring-up: acquisition cleared first, then the loop turned on
    wr(8'h04, 32'h00);
    rd(8'h04, 32'h00);
    wr(8'h00, 32'h20);
    rd(8'h00, 32'h20);
    give_verdict();
  end

endmodule : tb

`default_nettype wire
